// >>> rtl/count_gate_pkg.sv
// Behaviour
// - count 8-23 onto bus 48-63 on status and log-one stores
// - count parity onto bus 53-55, log three
// - equals-two when all bits but 19 zero
// - seq4 write chain equals-two: hold tail, retain
// - low-three-zero when bits 21-23 zero
// - read overrun sets chain check
// - less-than-two when all bits but 20 zero
// - write chain less-than-two: hold tail, retain
// - read chain new word small count checks
// - at-most-two is OR of three decodes
// - before decrement, at-most-two sets last word
// - at-most-one decode from bits 7-23
// - valid command word at-most-one sets last word
// - first below-one sample with A loaded checks
// - second below-one sample with byte excess checks
// - second sample skipped after first check
// - one count unit is eight bytes
// - decrement by one at bit 20
// - byte count equals tail clears count unless a tail is held
package count_gate_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] PAR_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] TAIL_OFS = 8'h10;
  // control field positions
  localparam int CTRL_READ = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_CHAIN = 2;
  localparam int CTRL_CLEAR = 3;
  // reset values; zero count carries odd parity ones
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [23:0] COUNT_RST = 24'h000000;
  localparam logic [2:0] PAR_RST = 3'h7;
  // decode masks, count bit 0 is the leftmost
  localparam logic [0:23] EQ2_MASK = 24'hFFFFEF;
  localparam logic [0:23] LT2_MASK = 24'hFFFFF7;
  localparam logic [0:23] MID_MASK = 24'h01FFF0;
  localparam logic [0:23] BELOW1_MASK = 24'h01FFF8;
  localparam logic [0:23] LOW3_MASK = 24'h000007;
  localparam int BIT20 = 20;
  // storage-in bus placement
  localparam int IN_BUS_CNT_LO = 48;
  localparam int IN_BUS_CNT_HI = 63;
  localparam int IN_BUS_PAR_LO = 53;
  localparam int IN_BUS_PAR_HI = 55;
  localparam int CNT_TO_BUS_LO = 8;
  // held tail is count bits 19-23
  localparam int TAIL_LO = 19;
  // bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } apb_state_type;
endpackage : count_gate_pkg

// >>> rtl/set_clear_latch.sv
module set_clear_latch (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_q
);
  // set outranks clear so a same-cycle event survives
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_q <= 1'b0;
    end else if (i_set) begin
      o_q <= 1'b1;
    end else if (i_clr) begin
      o_q <= 1'b0;
    end
  end
endmodule : set_clear_latch

// >>> rtl/count_char_decode.sv
module count_char_decode
  import count_gate_pkg::*;
(
  input wire logic [0:23] i_count,
  output logic o_eq2,
  output logic o_lt2,
  output logic o_le1,
  output logic o_lt1,
  output logic o_low3_zero,
  output logic o_le2
);
  // pure gates, so the sequencer sees the live count
  always_comb begin
    o_eq2 = ~|(i_count & EQ2_MASK);
    o_lt2 = ~|(i_count & LT2_MASK);
    o_low3_zero = ~|(i_count & LOW3_MASK);
    o_le1 = ~|(i_count & MID_MASK) &
      (~i_count[BIT20] | o_low3_zero);
    o_lt1 = ~|(i_count & BELOW1_MASK);
    o_le2 = o_eq2 | o_lt2 | o_le1;
  end
endmodule : count_char_decode

// >>> rtl/count_gate.sv
// The register addresses and the APB slave port are this design's own decisions.
module count_gate (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_seq1,
  input wire logic i_seq4_t2,
  input wire logic i_cmd_valid,
  input wire logic i_tail_add_done,
  input wire logic i_count_update,
  input wire logic i_byte_step,
  input wire logic [2:0] i_byte_counter,
  input wire logic i_byte_count_latches_zero,
  input wire logic i_a_reg_loaded,
  input wire logic i_store_status,
  input wire logic i_store_log1,
  input wire logic i_store_log3,
  output logic [0:63] o_storage_in_bus,
  output logic o_last_word,
  output logic o_chain_check,
  output logic o_retain_storage,
  output logic o_overrun,
  output logic [0:4] o_held_tail,
  output logic o_held_tail_par
);
  import count_gate_pkg::*;

  apb_state_type st_r;
  logic [2:0] ctrl_r;
  logic [0:23] count_r;
  logic [0:23] count_nxt;
  logic [0:2] par_r;
  logic first_hit_r;
  logic overrun_seen;
  logic eq2, lt2, le1, lt1, low3z, le2;
  logic rd, wr, chain;
  logic wr_fire, mapped;
  logic [31:0] rdata;
  logic clr;
  logic [2:0] tail_sel;
  logic byte_match, byte_gt_tail;
  logic held_take, ovr_evt, r9_evt, r14_evt, r15_evt;
  logic last_set, chk_set, count_clear;

  // odd parity per byte of the count
  function automatic logic [0:2] gen_par(input logic [0:23] v);
    gen_par = {~^v[0:7], ~^v[8:15], ~^v[16:23]};
  endfunction : gen_par

  count_char_decode u_decode (
    .i_count(count_r),
    .o_eq2(eq2),
    .o_lt2(lt2),
    .o_le1(le1),
    .o_lt1(lt1),
    .o_low3_zero(low3z),
    .o_le2(le2)
  );

  // mode bits from software
  assign rd = ctrl_r[CTRL_READ];
  assign wr = ctrl_r[CTRL_WRITE];
  assign chain = ctrl_r[CTRL_CHAIN];

  // bus write lands only on the completing edge
  assign wr_fire = (st_r == ST_ACK) & i_psel & i_penable & i_pwrite;
  assign clr = wr_fire & (i_paddr == CTRL_OFS) & i_pwdata[CTRL_CLEAR];

  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rdata = 32'h00000000;
    case (i_paddr)
      CTRL_OFS: rdata = {29'h00000000, ctrl_r};
      COUNT_OFS: rdata = {8'h00, count_r};
      PAR_OFS: rdata = {29'h00000000, par_r};
      STAT_OFS: rdata = {21'h000000, first_hit_r, le2, low3z, lt1,
        le1, lt2, eq2, overrun_seen, o_retain_storage,
        o_chain_check, o_last_word};
      TAIL_OFS: rdata = {26'h0000000, o_held_tail_par, o_held_tail};
      default: mapped = 1'b0;
    endcase
  end

  // one wait state, so read data comes from a flop
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (i_psel & i_penable) begin
            st_r <= ST_ACK;
            o_pready <= 1'b1;
            o_pslverr <= ~mapped;
            o_prdata <= i_pwrite ? 32'h00000000 : rdata;
          end
        end
        ST_ACK: begin
          st_r <= ST_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
          o_prdata <= 32'h00000000;
        end
        default: begin
          st_r <= ST_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
        end
      endcase
    end
  end

  // control register; clear bit is a self-clearing command
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_fire & (i_paddr == CTRL_OFS)) begin
      ctrl_r <= i_pwdata[2:0];
    end
  end

  // after a hand-off the ending is sensed on the held tail
  assign tail_sel = o_retain_storage ? o_held_tail[2:4] : count_r[21:23];
  assign byte_match = i_byte_step & o_last_word &
    (i_byte_counter == tail_sel);
  assign byte_gt_tail = i_byte_counter > count_r[21:23];
  // a held tail means the count already belongs to the next word
  assign count_clear = byte_match & ~o_retain_storage;

  // next count for a doubleword access, tail bits untouched
  assign count_nxt = {count_r[0:BIT20] - 21'h000001, count_r[21:23]};

  // hardware updates win over a software load in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      count_r <= COUNT_RST;
      par_r <= PAR_RST;
    end else if (count_clear) begin
      count_r <= COUNT_RST;
      par_r <= PAR_RST;
    end else if (i_count_update & (rd | wr)) begin
      count_r <= count_nxt;
      par_r <= gen_par(count_nxt);
    end else if (wr_fire & (i_paddr == COUNT_OFS)) begin
      count_r <= i_pwdata[23:0];
      par_r <= gen_par(i_pwdata[23:0]);
    end else if (wr_fire & (i_paddr == PAR_OFS)) begin
      par_r <= i_pwdata[2:0];
    end
  end

  // tail hand-off in write chaining
  assign held_take = i_seq4_t2 & wr & chain & (eq2 | lt2);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_held_tail <= 5'h00;
      o_held_tail_par <= 1'b1;
    end else if (held_take) begin
      o_held_tail <= count_r[TAIL_LO:23];
      o_held_tail_par <= par_r[2];
    end
  end

  set_clear_latch u_retain (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_set(held_take),
    .i_clr(clr | byte_match),
    .o_q(o_retain_storage)
  );

  // last-word trigger sources
  assign last_set =
    (i_count_update & (rd | wr) & le2) |
    (i_cmd_valid & (i_seq1 | (chain & (rd | wr))) & le1);

  set_clear_latch u_last (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_set(last_set),
    .i_clr(clr),
    .o_q(o_last_word)
  );

  // chain check sources
  assign ovr_evt = i_byte_step & rd & o_last_word &
    i_byte_count_latches_zero & ~low3z;
  assign r9_evt = i_cmd_valid & rd & chain & lt2 &
    i_a_reg_loaded & byte_gt_tail;
  assign r14_evt = i_cmd_valid & rd & chain & lt1 &
    i_a_reg_loaded;
  // second look only when the first found nothing
  assign r15_evt = i_tail_add_done & rd & chain & lt1 &
    byte_gt_tail & ~first_hit_r;
  assign chk_set = ovr_evt | r9_evt | r14_evt | r15_evt;

  set_clear_latch u_check (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_set(chk_set),
    .i_clr(clr),
    .o_q(o_chain_check)
  );

  set_clear_latch u_ovr (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_set(ovr_evt),
    .i_clr(clr),
    .o_q(overrun_seen)
  );

  // remembers the first sample's outcome for this command word
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      first_hit_r <= 1'b0;
    end else if (i_cmd_valid) begin
      first_hit_r <= r14_evt;
    end
  end

  // overrun pulse for the sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_overrun <= 1'b0;
    end else begin
      o_overrun <= ovr_evt;
    end
  end

  // storage-in gating; bus idles at zero between stores
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_storage_in_bus <= 64'h0000000000000000;
    end else begin
      o_storage_in_bus <= 64'h0000000000000000;
      if (i_store_status | i_store_log1) begin
        o_storage_in_bus[IN_BUS_CNT_LO:IN_BUS_CNT_HI] <=
          count_r[CNT_TO_BUS_LO:23];
      end else if (i_store_log3) begin
        o_storage_in_bus[IN_BUS_PAR_LO:IN_BUS_PAR_HI] <= par_r;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_tail_take;
    i_seq4_t2 && wr && chain && (eq2 || lt2);
  endsequence

  sequence s_tail_held;
    o_retain_storage && (o_held_tail == $past(count_r[19:23]));
  endsequence

  sequence s_cmd_small;
    i_cmd_valid && rd && chain && lt1 && i_a_reg_loaded;
  endsequence

  a_bus_count: assert property (
    (i_store_status || i_store_log1) |=>
      o_storage_in_bus[48:63] == $past(count_r[8:23]))
    else $error("count not on storage-in bus");

  a_bus_parity: assert property (
    (i_store_log3 && !i_store_status && !i_store_log1) |=>
      (o_storage_in_bus[53:55] == $past(par_r)) &&
      (o_storage_in_bus[48:52] == 5'h00))
    else $error("parity not on storage-in bus");

  a_tail_hold: assert property (
    s_tail_take |=> s_tail_held)
    else $error("tail not held on hand-off");

  a_overrun_chk: assert property (
    (i_byte_step && rd && o_last_word && i_byte_count_latches_zero &&
      (count_r[21:23] != 3'h0)) |=> o_chain_check && o_overrun)
    else $error("overrun missed");

  a_last_decr: assert property (
    (i_count_update && (rd || wr) && (count_r[7:20] == 14'h0000))
      |=> o_last_word)
    else $error("last word not set at decrement");

  a_decrement: assert property (
    (i_count_update && (rd || wr) && !count_clear) |=>
      (count_r[0:20] == $past(count_r[0:20]) - 21'h000001) &&
      $stable(count_r[21:23]))
    else $error("count not decremented by one unit");

  a_bc_clear: assert property (
    (count_clear) |=> (count_r == 24'h000000) && (par_r == 3'h7))
    else $error("count not cleared at byte match");

  a_first_chk: assert property (
    s_cmd_small |=> o_chain_check && first_hit_r)
    else $error("first below-one sample missed");

  a_second_skip: assert property (
    (first_hit_r && i_tail_add_done && !i_cmd_valid) |-> !r15_evt)
    else $error("second sample taken after check");

  a_le2_decode: assert property (
    (le2 && !o_last_word && i_count_update && (rd || wr) && !clr)
      |=> o_last_word ##1 (o_last_word || $past(clr)))
    else $error("at-most-two did not hold last word");

  a_eq2_effect: assert property (
    (i_seq4_t2 && !wr) |=> $stable(o_held_tail))
    else $error("equals-two acted outside write");

  // decode written out from count bits, not from the decoder
  a_cmd_last: assert property (
    (i_cmd_valid && (i_seq1 || (chain && (rd || wr))) &&
      (count_r[7:19] == 13'h0000) &&
      (!count_r[20] || (count_r[21:23] == 3'h0))) |=> o_last_word)
    else $error("last word not set on command word");

  a_small_new: assert property (
    (i_cmd_valid && rd && chain && i_a_reg_loaded &&
      ((count_r & LT2_MASK) == 24'h000000) &&
      (i_byte_counter > count_r[21:23])) |=> o_chain_check)
    else $error("small new count check missed");

  a_second_chk: assert property (
    (i_tail_add_done && rd && chain && !first_hit_r &&
      (count_r[7:20] == 14'h0000) &&
      (i_byte_counter > count_r[21:23])) |=> o_chain_check)
    else $error("second below-one sample missed");

endmodule : count_gate

// >>> dv/seq_partner.sv
module seq_partner (
  input wire logic i_core_clk,
  output logic o_seq1,
  output logic o_seq4_t2,
  output logic o_cmd_valid,
  output logic o_tail_add_done,
  output logic o_count_update,
  output logic o_byte_step,
  output logic o_store_status,
  output logic o_store_log1,
  output logic o_store_log3,
  output logic [2:0] o_byte_counter,
  output logic o_latches_zero,
  output logic o_a_loaded
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] strobe_r;

  // strobes share one vector so a call can raise only one of them
  assign {o_store_log3, o_store_log1, o_store_status, o_byte_step,
    o_count_update, o_tail_add_done, o_cmd_valid, o_seq4_t2} = strobe_r;

  // sequencer idles with every strobe and level low
  initial begin
    strobe_r = 8'h00;
    o_seq1 = 1'b0;
    o_byte_counter = 3'h0;
    o_latches_zero = 1'b0;
    o_a_loaded = 1'b0;
  end

  // levels change right after an edge and hold until the next call
  task automatic levels(input logic s1, input logic lz, input logic al,
    input logic [2:0] cnt);
    @(posedge i_core_clk);
    o_seq1 <= s1;
    o_latches_zero <= lz;
    o_a_loaded <= al;
    o_byte_counter <= cnt;
  endtask : levels

  // one strobe for one cycle; launched after an edge, taken at the next
  task automatic fire(input int n);
    @(posedge i_core_clk);
    strobe_r <= 8'(32'h1 << n);
    @(posedge i_core_clk);
    strobe_r <= 8'h00;
  endtask : fire
endmodule : seq_partner

// >>> dv/test_count_gate.sv
module test_count_gate;
  timeunit 1ns;
  timeprecision 1ns;
  import count_gate_pkg::*;
  logic clk, rst_n, psel, pen, pwr, seq1, blz, aload, err;
  logic pready, pslverr, lastw, cchk, ret, ovr, hpar;
  logic s4t2, cmdv, tadd, cupd, bstep, sstat, slog1, slog3;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] byte_cnt;
  logic [0:63] in_bus;
  logic [0:4] htail;
  int fail_count, checks;
  // count written, expected {le2,low3,lt1,le1,lt2,eq2}
  logic [23:0] cnt_tab [8] = '{24'h000000, 24'h000010, 24'h000008,
    24'h00000F, 24'h000005, 24'h000018, 24'h800000, 24'h010000};
  logic [5:0] dec_tab [8] = '{6'h3F, 6'h31, 6'h36, 6'h00, 6'h2C,
    6'h10, 6'h3C, 6'h10};

  count_gate i_count_gate (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_seq1(seq1), .i_seq4_t2(s4t2),
    .i_cmd_valid(cmdv), .i_tail_add_done(tadd),
    .i_count_update(cupd), .i_byte_step(bstep),
    .i_byte_counter(byte_cnt),
    .i_byte_count_latches_zero(blz), .i_a_reg_loaded(aload),
    .i_store_status(sstat), .i_store_log1(slog1),
    .i_store_log3(slog3), .o_storage_in_bus(in_bus),
    .o_last_word(lastw),
    .o_chain_check(cchk), .o_retain_storage(ret), .o_overrun(ovr),
    .o_held_tail(htail), .o_held_tail_par(hpar));
  seq_partner i_seq_partner (.i_core_clk(clk), .o_seq1(seq1),
    .o_seq4_t2(s4t2), .o_cmd_valid(cmdv), .o_tail_add_done(tadd),
    .o_count_update(cupd), .o_byte_step(bstep), .o_store_status(sstat),
    .o_store_log1(slog1), .o_store_log3(slog3),
    .o_byte_counter(byte_cnt), .o_latches_zero(blz), .o_a_loaded(aload));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // apb master; waits for pready, takes data at that edge only
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    // no cycle count assumed; only the watchdog ends a lost answer
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb

  task test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    fail_count++;
    test_done;
  end

  initial begin
    rst_n = 1'h0;
    {psel, pen, pwr} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    #1 chk(32'({lastw, cchk, ret, ovr, hpar}), 32'h1);
    @(posedge clk);
    rst_n <= 1'h1;
    apb(0, CTRL_OFS, 0);
    chk(rdat, 32'h0);
    chk(32'(err), 32'h0);
    apb(0, PAR_OFS, 0);
    chk(rdat, 32'h7);
    apb(0, TAIL_OFS, 0);
    chk(rdat, 32'h20);
    // unmapped word refused both ways, read gives zero
    apb(1, 8'h14, 32'hFFFFFFFF);
    chk(32'(err), 32'h1);
    apb(0, 8'h14, 0);
    chk(32'(err), 32'h1);
    chk(rdat, 32'h0);
    // decode table, parity recomputed from the written count
    for (int i = 0; i < 8; i++) begin
      apb(1, COUNT_OFS, {8'h00, cnt_tab[i]});
      apb(0, COUNT_OFS, 0);
      chk(rdat, {8'h00, cnt_tab[i]});
      apb(0, STAT_OFS, 0);
      chk(32'(rdat[9:4]), 32'(dec_tab[i]));
      apb(0, PAR_OFS, 0);
      chk(rdat, 32'({~^cnt_tab[i][23:16], ~^cnt_tab[i][15:8],
        ~^cnt_tab[i][7:0]}));
    end
    // storage-in bus for status, log word one and log word three
    apb(1, COUNT_OFS, 32'h00ABCD);
    i_seq_partner.fire(5);
    #1 chk(32'(in_bus[48:63]), 32'hABCD);
    i_seq_partner.fire(6);
    #1 chk(32'(in_bus[48:63]), 32'hABCD);
    i_seq_partner.fire(7);
    #1 chk(32'(in_bus[53:55]), 32'h4);
    // write: decrement by one doubleword, last word, then count clear
    apb(1, CTRL_OFS, 32'hA);
    apb(1, COUNT_OFS, 32'h18);
    i_seq_partner.fire(3);
    #1 chk(32'(lastw), 32'h0);
    apb(0, COUNT_OFS, 0);
    chk(rdat, 32'h10);
    i_seq_partner.fire(3);
    #1 chk(32'(lastw), 32'h1);
    apb(0, COUNT_OFS, 0);
    chk(rdat, 32'h8);
    i_seq_partner.fire(4);
    apb(0, COUNT_OFS, 0);
    chk(rdat, 32'h0);
    // write chaining: tail handed off for equals-two and less-than-two
    apb(1, CTRL_OFS, 32'hE);
    apb(1, COUNT_OFS, 32'h10);
    i_seq_partner.fire(0);
    #1 chk(32'({htail, hpar, ret}), 32'h41);
    apb(1, CTRL_OFS, 32'hE);
    apb(1, COUNT_OFS, 32'h08);
    i_seq_partner.fire(0);
    #1 chk(32'({htail, hpar, ret}), 32'h21);
    // read: initial selection sets last word, then overrun
    apb(1, CTRL_OFS, 32'h9);
    apb(1, COUNT_OFS, 32'h3);
    i_seq_partner.levels(1'h1, 1'h0, 1'h0, 3'h0);
    i_seq_partner.fire(1);
    #1 chk(32'(lastw), 32'h1);
    i_seq_partner.levels(1'h0, 1'h1, 1'h0, 3'h1);
    i_seq_partner.fire(4);
    #1 chk(32'({ovr, cchk}), 32'h3);
    // read chaining: both below-one samplings and the small new count
    apb(1, CTRL_OFS, 32'hD);
    apb(1, COUNT_OFS, 32'h0);
    i_seq_partner.levels(1'h0, 1'h0, 1'h1, 3'h1);
    i_seq_partner.fire(1);
    #1 chk(32'(cchk), 32'h1);
    apb(0, STAT_OFS, 0);
    chk(32'(rdat[10]), 32'h1);
    // latches cleared but first hit kept: second sample stays skipped
    apb(1, CTRL_OFS, 32'hD);
    i_seq_partner.fire(2);
    #1 chk(32'(cchk), 32'h0);
    apb(1, CTRL_OFS, 32'hD);
    apb(1, COUNT_OFS, 32'h1);
    i_seq_partner.levels(1'h0, 1'h0, 1'h0, 3'h5);
    i_seq_partner.fire(1);
    #1 chk(32'(cchk), 32'h0);
    i_seq_partner.fire(2);
    #1 chk(32'(cchk), 32'h1);
    apb(1, CTRL_OFS, 32'hD);
    apb(1, COUNT_OFS, 32'h08);
    i_seq_partner.levels(1'h0, 1'h0, 1'h1, 3'h5);
    i_seq_partner.fire(1);
    #1 chk(32'(cchk), 32'h1);
    // reset in mid-run: latches, held tail and count drop back
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk(32'({lastw, cchk, ret, ovr, hpar}), 32'h1);
    @(posedge clk);
    rst_n <= 1'h1;
    apb(0, COUNT_OFS, 0);
    chk(rdat, 32'h0);
    apb(0, PAR_OFS, 0);
    chk(rdat, 32'h7);
    test_done;
  end
endmodule : test_count_gate
